// ### ipfp_pkg.sv
// package of shared constants and the input synchroniser module
// assumes one free-running 40 MHz clock and an active-low asynchronous reset
package ipfp_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int BLANK_NS = 810;
    localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_NS = 900;
    localparam int DELAY_CYC = (DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OVL_NS = 800;
    localparam int OVL_CYC = (OVL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_MS = 10;
    localparam int HOLD_CYC = (HOLD_MS * 1000000) / CLK_PERIOD_NS;
    // ----------------------------------------------------------------
    // short-circuit sequencer
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        IPFP_SC_IDLE = 2'h0,
        IPFP_SC_BLANK = 2'h1,
        IPFP_SC_DELAY = 2'h3,
        IPFP_SC_HOLD = 2'h2
    } ipfp_sc_t;
    localparam logic [2:0] FAULT_DRIVE_RST = 3'h0;
endpackage

`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// three-stage synchroniser, output moves once stages two and three agree
// ----------------------------------------------------------------
module ipfp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] f;
    } ipfp_sync_state_t;

    ipfp_sync_state_t st_r;
    ipfp_sync_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.f[i] = st_r.s2[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= {INIT, INIT, INIT, INIT};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.f;
endmodule
`default_nettype wire

// ### ipfp_protect.sv
// three-phase gate protection: short-circuit trip, overlap block, thermal trip
// assumes async pin inputs; fault wire resolved outside from the enables
`timescale 1ns/10ps
`default_nettype none
module ipfp_protect #(
    parameter int HOLD_CYCLES = ipfp_pkg::HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] high_side_command,
    input wire logic [2:0] low_side_command,
    input wire logic middle_phase_low_emitter_sense,
    input wire logic [1:0] thermal_trip_level,
    input wire logic [1:0] thermal_release_level,
    input wire logic fault_line_n_in,
    output logic [2:0] fault_line_n_out,
    output logic [2:0] fault_line_n_oe_n,
    output logic [2:0] high_gate_drive,
    output logic [2:0] low_gate_drive
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);
    localparam int OW = $clog2(ipfp_pkg::OVL_CYC + 1);
    localparam int BLANK_D = ipfp_pkg::BLANK_CYC;
    localparam int DELAY_D = ipfp_pkg::DELAY_CYC;
    localparam int DELAY_D1 = ipfp_pkg::DELAY_CYC + 1;
    localparam int OVL_D = ipfp_pkg::OVL_CYC;

    typedef struct packed {
        ipfp_pkg::ipfp_sc_t sc;
        logic [CW-1:0] sc_cnt;
        logic [2:0][OW-1:0] ovl_cnt;
        logic [2:0] ovl;
        logic [1:0] thermal_trip;
        logic [2:0] hi;
        logic [2:0] lo;
        logic [2:0] drv;
    } ipfp_state_t;

    ipfp_state_t st_r;
    ipfp_state_t st_nxt;
    logic [11:0] sync_f;
    logic [2:0] hi_f;
    logic [2:0] lo_f;
    logic sense_f;
    logic [1:0] hot_f;
    logic [1:0] warm_f;
    logic line_f;
    logic [2:0] ovl_raw;
    logic [2:0] own_fault;
    logic sc_blank_w;
    logic sc_delay_w;
    logic sc_hold_w;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // fault wire resets to its idle high level so nothing trips at release
    ipfp_sync #(
        .W(12),
        .INIT(12'h800)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .din({fault_line_n_in, thermal_release_level, thermal_trip_level,
              middle_phase_low_emitter_sense, low_side_command, high_side_command}),
        .dout(sync_f)
    );

    assign hi_f = sync_f[2:0];
    assign lo_f = sync_f[5:3];
    assign sense_f = sync_f[6];
    assign hot_f = sync_f[8:7];
    assign warm_f = sync_f[10:9];
    assign line_f = sync_f[11];
    assign ovl_raw = hi_f & lo_f;
    assign sc_blank_w = (st_r.sc == ipfp_pkg::IPFP_SC_BLANK);
    assign sc_delay_w = (st_r.sc == ipfp_pkg::IPFP_SC_DELAY);
    assign sc_hold_w = (st_r.sc == ipfp_pkg::IPFP_SC_HOLD);
    // outer phases carry the thermal trip, the middle one the short trip
    assign own_fault = {st_r.thermal_trip[1], sc_hold_w, st_r.thermal_trip[0]} | st_r.ovl;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        unique case (st_r.sc)
            ipfp_pkg::IPFP_SC_IDLE: begin
                if (sense_f) begin
                    st_nxt.sc = ipfp_pkg::IPFP_SC_BLANK;
                    st_nxt.sc_cnt = CW'(1);
                end
            end
            ipfp_pkg::IPFP_SC_BLANK: begin
                if (!sense_f) begin
                    // short pulses fall back without a trace
                    st_nxt.sc = ipfp_pkg::IPFP_SC_IDLE;
                    st_nxt.sc_cnt = '0;
                end else if (st_r.sc_cnt == CW'(ipfp_pkg::BLANK_CYC)) begin
                    st_nxt.sc = ipfp_pkg::IPFP_SC_DELAY;
                    st_nxt.sc_cnt = CW'(1);
                end else begin
                    st_nxt.sc_cnt = st_r.sc_cnt + CW'(1);
                end
            end
            ipfp_pkg::IPFP_SC_DELAY: begin
                if (st_r.sc_cnt == CW'(ipfp_pkg::DELAY_CYC)) begin
                    st_nxt.sc = ipfp_pkg::IPFP_SC_HOLD;
                    st_nxt.sc_cnt = CW'(1);
                end else begin
                    st_nxt.sc_cnt = st_r.sc_cnt + CW'(1);
                end
            end
            ipfp_pkg::IPFP_SC_HOLD: begin
                // hold runs its full length whatever the comparator does
                if (st_r.sc_cnt == CW'(HOLD_CYCLES)) begin
                    st_nxt.sc = ipfp_pkg::IPFP_SC_IDLE;
                    st_nxt.sc_cnt = '0;
                end else begin
                    st_nxt.sc_cnt = st_r.sc_cnt + CW'(1);
                end
            end
        endcase
        for (int p = 0; p < 3; p++) begin
            if (!ovl_raw[p]) begin
                st_nxt.ovl_cnt[p] = '0;
                st_nxt.ovl[p] = 1'b0;
            end else if (st_r.ovl_cnt[p] == OW'(ipfp_pkg::OVL_CYC)) begin
                st_nxt.ovl[p] = 1'b1;
            end else begin
                st_nxt.ovl_cnt[p] = st_r.ovl_cnt[p] + OW'(1);
            end
        end
        for (int t = 0; t < 2; t++) begin
            if (hot_f[t]) begin
                st_nxt.thermal_trip[t] = 1'b1;
            end else if (!warm_f[t]) begin
                st_nxt.thermal_trip[t] = 1'b0;
            end
        end
        // gates lag one cycle behind the fault state; shared wire shuts every phase
        st_nxt.hi = hi_f & ~own_fault & {3{line_f}};
        st_nxt.lo = lo_f & ~own_fault & {3{line_f}};
        st_nxt.drv = own_fault;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{sc: ipfp_pkg::IPFP_SC_IDLE, drv: ipfp_pkg::FAULT_DRIVE_RST, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // open drain: the pin only ever pulls low
    assign fault_line_n_out = 3'h0;
    assign fault_line_n_oe_n = ~st_r.drv;
    assign high_gate_drive = st_r.hi;
    assign low_gate_drive = st_r.lo;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_blank_abort: assert property (sc_blank_w && !sense_f |=> st_r.sc == ipfp_pkg::IPFP_SC_IDLE)
        else $error("short pulse not discarded");
    chk_blank_length: assert property ($rose(sc_delay_w) |-> $past(sc_blank_w, BLANK_D))
        else $error("blanking shorter than required");
    chk_delay_length: assert property ($rose(sc_hold_w) |->
        $past(sc_delay_w, DELAY_D) && !$past(sc_delay_w, DELAY_D1))
        else $error("trip delay wrong length");
    chk_trip_gates: assert property ($rose(sc_hold_w) |=>
        (!high_gate_drive[1] && !low_gate_drive[1] && !fault_line_n_oe_n[1]) [*8])
        else $error("middle phase not shut after trip");
    chk_hold_stays: assert property (sc_hold_w && st_r.sc_cnt != CW'(HOLD_CYCLES) |=> sc_hold_w)
        else $error("fault hold ended early");
    chk_ovl_filter: assert property ($rose(st_r.ovl[0]) |-> $past(ovl_raw[0], OVL_D))
        else $error("overlap acted before filter time");
    chk_ovl_gates: assert property ((($past(st_r.ovl) & (high_gate_drive | low_gate_drive)) == 3'h0)
        && (($past(st_r.ovl) & fault_line_n_oe_n) == 3'h0))
        else $error("overlap phase left driving");
    chk_ovl_release: assert property (!ovl_raw[2] |=> !st_r.ovl[2] ##1
        !fault_line_n_oe_n[2] == $past(st_r.thermal_trip[1]))
        else $error("overlap fault outlived overlap");
    chk_tsd_hyst: assert property (st_r.thermal_trip[0] && warm_f[0] |=> st_r.thermal_trip[0] && !fault_line_n_oe_n[0])
        else $error("thermal trip released above release level");
    chk_tsd_gates: assert property (hot_f[1] |=> ##1 !high_gate_drive[2] && !low_gate_drive[2])
        else $error("hot phase still driving");
    chk_line_obey: assert property (!line_f |=> high_gate_drive == 3'h0 && low_gate_drive == 3'h0)
        else $error("gates on while fault wire low");
    // each pull follows its cause one cycle later
    chk_hold_pull: assert property (sc_hold_w |=> !fault_line_n_oe_n[1])
        else $error("middle fault released during hold");
    chk_ovl_pull: assert property (st_r.ovl[1] |=> !fault_line_n_oe_n[1])
        else $error("overlap fault not signalled");
    // an outer phase never pulls for the middle phase's trip
    chk_outer_quiet: assert property (!st_r.thermal_trip[0] && !st_r.ovl[0] |=> fault_line_n_oe_n[0])
        else $error("outer phase pulled without its own fault");
    chk_tsd_release: assert property (st_r.thermal_trip[1] && !hot_f[1] && !warm_f[1] |=> !st_r.thermal_trip[1])
        else $error("thermal trip held below release level");
    chk_blank_keeps: assert property (sc_blank_w && sense_f &&
        st_r.sc_cnt != CW'(ipfp_pkg::BLANK_CYC) |=> sc_blank_w)
        else $error("blanking left before its end");
endmodule
`default_nettype wire

// ### ipfp_mcu_model.sv
// controller model: turns wanted commands into phase command pins
// assumes the bench resolves the shared fault wire
`timescale 1ns/10ps
`default_nettype none
module ipfp_mcu_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic fault_line_n,
    input wire logic obey_fault,
    input wire logic allow_overlap,
    input wire logic [2:0] want_high,
    input wire logic [2:0] want_low,
    output logic [2:0] high_side_command,
    output logic [2:0] low_side_command
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            high_side_command <= 3'h0;
            low_side_command <= 3'h0;
        end else if (obey_fault && !fault_line_n) begin
            high_side_command <= 3'h0;
            low_side_command <= 3'h0;
        end else begin
            // unless allow_overlap is set, one side rises only if the other was off the cycle before; both can still rise together from both off
            high_side_command <= want_high & (allow_overlap ? 3'h7 : ~low_side_command);
            low_side_command <= want_low & (allow_overlap ? 3'h7 : ~high_side_command);
        end
    end
endmodule
`default_nettype wire

// ### test_inverter_phase_fault_protection.sv
// bench for the phase protection block, driven through the controller model
// assumes a 40 MHz clock and a shortened fault hold
`timescale 1ns/10ps
`default_nettype none
module test_inverter_phase_fault_protection;
    localparam int HOLD = 64;
    localparam int SCT = ipfp_pkg::BLANK_CYC + ipfp_pkg::DELAY_CYC;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sense = 1'b0;
    logic ovl = 1'b0;
    logic seen = 1'b0;
    logic [1:0] trip = 2'h0;
    logic [1:0] rel = 2'h0;
    logic [2:0] wh = 3'h0;
    logic [2:0] wl = 3'h0;
    logic [2:0] hc, lc, oe_n, hg, lg;
    logic [2:0] fo;
    logic wire_n;
    int error_cnt = 0;
    int compares = 0;
    int n;
    // ----------------------------------------------------------------
    // shared fault wire, pulled up
    // ----------------------------------------------------------------
    assign wire_n = &oe_n;
    always @(negedge clk) if (!wire_n) seen = 1'b1;
    ipfp_mcu_model u_ipfp_mcu_model (.clk(clk), .rst_b(rst_b), .fault_line_n(wire_n),
        .obey_fault(1'b0), .allow_overlap(ovl), .want_high(wh), .want_low(wl),
        .high_side_command(hc), .low_side_command(lc));
    ipfp_protect #(.HOLD_CYCLES(HOLD)) u_ipfp_protect (.clk(clk), .rst_b(rst_b),
        .high_side_command(hc), .low_side_command(lc),
        .middle_phase_low_emitter_sense(sense), .thermal_trip_level(trip),
        .thermal_release_level(rel), .fault_line_n_in(wire_n), .fault_line_n_out(fo),
        .fault_line_n_oe_n(oe_n), .high_gate_drive(hg), .low_gate_drive(lg));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
    endtask
    // sample at the falling edge so registered outputs have settled
    task automatic look(input int k);
        step(k);
        @(negedge clk);
    endtask
    task automatic wait_oe(input int p, input logic v, input int lim);
        n = 0;
        @(negedge clk);
        while (oe_n[p] !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic report_and_stop;
        $display("compares=%0d mismatches=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic t_short;
        seen = 1'b0;
        step(1);
        sense <= 1'b1;
        step(20);
        sense <= 1'b0;
        look(100);
        chk(32'(seen), 32'h0);
        step(1);
        sense <= 1'b1;
        wait_oe(1, 1'b0, 120);
        chk(32'(n >= SCT && n <= SCT + 10), 32'h1);
        step(1);
        sense <= 1'b0;
        look(10);
        chk(32'({oe_n, hg, lg}), 32'h140);
        wait_oe(1, 1'b1, HOLD + 20);
        chk(32'(n >= HOLD - 14 && n <= HOLD - 8), 32'h1);
        look(10);
        chk(32'({hg, lg}), 32'h2A);
        $display("test short trip done");
    endtask
    task automatic t_overlap;
        step(1);
        ovl <= 1'b1;
        seen = 1'b0;
        wl <= 3'h3;
        look(20);
        step(1);
        wl <= 3'h2;
        look(10);
        chk(32'(seen), 32'h0);
        step(1);
        wl <= 3'h3;
        wait_oe(0, 1'b0, 60);
        chk(32'(n >= ipfp_pkg::OVL_CYC && n <= ipfp_pkg::OVL_CYC + 10), 32'h1);
        look(60);
        chk(32'({oe_n, hg[0], lg[0]}), 32'h18);
        step(1);
        wl <= 3'h2;
        // one model cycle, four sync cycles, then overlap flag and pull clear
        wait_oe(0, 1'b1, 12);
        chk(32'(n <= 8), 32'h1);
        look(8);
        chk(32'({hg, lg}), 32'h2A);
        step(1);
        ovl <= 1'b0;
        $display("test overlap done");
    endtask
    task automatic t_thermal;
        for (int b = 0; b < 2; b++) begin
            step(1);
            trip[b] <= 1'b1;
            rel[b] <= 1'b1;
            wait_oe(2 * b, 1'b0, 10);
            look(8);
            chk(32'({oe_n, hg, lg}), (b == 1) ? 32'hC0 : 32'h180);
            step(1);
            trip[b] <= 1'b0;
            look(20);
            chk(32'(oe_n[2 * b]), 32'h0);
            step(1);
            rel[b] <= 1'b0;
            look(14);
            chk(32'({oe_n, hg, lg}), 32'h1EA);
        end
        $display("test thermal done");
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 20000);
        error_cnt++;
        report_and_stop;
    end
    initial begin
        step(4);
        @(negedge clk);
        chk(32'({oe_n, hg, lg}), 32'h1C0);
        chk(32'(fo), 32'h0);
        step(1);
        rst_b <= 1'b1;
        wh <= 3'h5;
        wl <= 3'h2;
        look(8);
        chk(32'({hg, lg}), 32'h2A);
        t_short;
        t_overlap;
        t_thermal;
        report_and_stop;
    end
endmodule
`default_nettype wire
